// ==== verilog/sram_host_pkg.sv ====
/*
 * Constants for the host-side controller of a 32K x 8 asynchronous static memory.
 * Assumes a 10 MHz system clock; all memory timing is met in whole cycles.
 */
package sram_host_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    // Slowest-grade limits, in ns
    localparam int ADDR_VALID_TO_WRITE_END_NS = 85;
    localparam int WRITE_PULSE_MIN_NS = 55;
    localparam int STROBE_TO_OUTPUT_FLOAT_NS = 50;
    localparam int DATA_SETUP_TO_WRITE_END_NS = 70;
    localparam int SELECT_TO_WRITE_END_NS = 90;
    localparam int WRITE_RECOVERY_NS = 0;
    localparam int CYCLE_TIME_MIN_NS = 100;
    localparam int ADDR_ACCESS_NS = 100;
    // Pulse must cover float plus set-up when output enable may be low
    localparam int PULSE_NEED_NS = (WRITE_PULSE_MIN_NS > STROBE_TO_OUTPUT_FLOAT_NS
        + DATA_SETUP_TO_WRITE_END_NS) ? WRITE_PULSE_MIN_NS
        : STROBE_TO_OUTPUT_FLOAT_NS + DATA_SETUP_TO_WRITE_END_NS;
    localparam int WR_PULSE_CYC_I = (PULSE_NEED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_CYC_I = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CYC_I = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WR_PULSE_CYC = 4'(WR_PULSE_CYC_I < 1 ? 1 : WR_PULSE_CYC_I);
    localparam logic [3:0] RD_ACCESS_CYC = 4'(RD_ACCESS_CYC_I < 1 ? 1 : RD_ACCESS_CYC_I);
    localparam logic [3:0] RECOV_CYC = 4'(RECOV_CYC_I < 1 ? 1 : RECOV_CYC_I);
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_RECOV,
        ST_RD_ACCESS,
        ST_RD_DONE
    } state_t;
endpackage

// ==== verilog/sram_host_ctrl.sv ====
/*
 * Host controller driving an asynchronous 32K x 8 static memory through its pins.
 * A write taken on edge 0 (i_req high while o_ready is high) runs:
 *   edge 1: select and strobe fall together, data bus driven, output enable high
 *   edge 1 + WR_PULSE_CYC: select and strobe rise together
 *   next edge: data bus released and o_ready high again
 * Write recovery keeps address and data standing for one cycle after the strobe rises.
 * A read taken on edge 0 runs:
 *   edge 1: select and output enable fall, strobe stays high
 *   edge 1 + RD_ACCESS_CYC: access time spent, wait state entered
 *   edge 2 + RD_ACCESS_CYC: bus value held in the second synchroniser stage
 *   edge 3 + RD_ACCESS_CYC: read data registered, o_rvalid pulses, pins in standby
 * A request seen while o_ready is low is dropped; nothing shows for it.
 * Output enable stays high through writes, yet the pulse still covers float plus set-up.
 * Every pin comes straight from the state register.
 * The memory has no clock; all its timing is met by counting i_clk cycles.
 * Assumes the request side is on i_clk and the memory read data arrives asynchronously.
 * Assumes a 10 MHz clock, so every slowest-grade minimum fits in whole cycles.
 */
//
// Overview of operation
// RQ1: Address changes only while write strobe high.
// RQ2: Write happens while select and strobe low.
// RQ3: Address valid long before write end.
// RQ4: Address held after strobe rises.
// RQ5: Host releases data bus during write recovery; the code drives it through the recovery cycle and releases it as recovery ends.
// RQ6: Select falls with strobe; outputs stay floating.
// RQ7: Strobe pulse covers float plus set-up.
// RQ8: Output enable high allows minimum pulse.
// RQ9: Write strobe high during every read.
// RQ10: Address valid before select falls.
// RQ11: Address-controlled read needs no strobe toggle.
// RQ12: Write data valid before write end.
// RQ13: Select low long before write end.
// RQ14: Old read data held after address change.
// RQ15: Select high puts memory in standby.
// RQ16: Memory drives data only with output enable low.
`timescale 1ns/10ps
module sram_host_ctrl (
    input wire logic i_clk, // System clock, 10 MHz
    input wire logic i_sys_rst, // Asynchronous reset, active high
    input wire logic i_req, // Request pulse or level, taken when ready
    input wire logic i_we, // 1 write, 0 read
    input wire logic [14:0] i_addr, // Request address
    input wire logic [7:0] i_wdata, // Write data
    output logic o_ready, // Idle and able to take a request
    output logic o_rvalid, // One-cycle read data valid
    output logic [7:0] o_rdata, // Read data
    output logic [14:0] o_mem_addr, // Memory address pins
    output logic o_mem_sel_n, // Chip select, active low
    output logic o_mem_wr_n, // Write strobe, active low
    output logic o_mem_oe_n, // Output enable, active low
    output logic [7:0] o_mem_dq_o, // Data bus output value
    output logic o_mem_dq_oe, // Data bus drive enable, high drives
    input wire logic [7:0] i_mem_dq_i // Data bus input value
);

    typedef struct packed {
        sram_host_pkg::state_t st;
        logic [3:0] cnt;
        logic ready;
        logic rvalid;
        logic [7:0] rdata;
        logic [14:0] addr;
        logic sel_n;
        logic wr_n;
        logic oe_n;
        logic [7:0] dq_o;
        logic dq_oe;
        logic [7:0] sync1;
        logic [7:0] sync2;
    } ctrl_t;

    // Reset image: memory in standby, bus released, ready for a request
    localparam ctrl_t CTRL_RST = '{
        st: sram_host_pkg::ST_IDLE,
        cnt: sram_host_pkg::CNT_ZERO,
        ready: 1'b1,
        rvalid: 1'b0,
        rdata: sram_host_pkg::DATA_RST,
        addr: sram_host_pkg::ADDR_RST,
        sel_n: 1'b1,
        wr_n: 1'b1,
        oe_n: 1'b1,
        dq_o: sram_host_pkg::DATA_RST,
        dq_oe: 1'b0,
        sync1: sram_host_pkg::DATA_RST,
        sync2: sram_host_pkg::DATA_RST
    };

    ctrl_t s_r;
    ctrl_t s_nxt;
    logic cnt_last;
    logic cnt_spent;
    logic [3:0] cnt_dec;

    // Shared counter decodes for every timed state
    assign cnt_last = (s_r.cnt == sram_host_pkg::CNT_ONE);
    assign cnt_spent = (s_r.cnt == sram_host_pkg::CNT_ZERO);
    assign cnt_dec = s_r.cnt - sram_host_pkg::CNT_ONE;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        // Both synchroniser stages shift every cycle; only the second is read
        s_nxt.sync1 = i_mem_dq_i;
        s_nxt.sync2 = s_r.sync1;

        unique case (s_r.st)
            sram_host_pkg::ST_IDLE: begin
                // Memory in standby; address moves only with strobe high
                s_nxt.sel_n = 1'b1; // [RQ15]
                s_nxt.wr_n = 1'b1; // [RQ1]
                s_nxt.oe_n = 1'b1;
                s_nxt.dq_oe = 1'b0;
                // Requests are taken only here, so a busy request is dropped
                if (i_req) begin
                    s_nxt.ready = 1'b0;
                    s_nxt.addr = i_addr; // [RQ1] [RQ10]
                    if (i_we) begin
                        s_nxt.dq_o = i_wdata;
                        s_nxt.st = sram_host_pkg::ST_WR_SETUP;
                    end else begin
                        s_nxt.cnt = sram_host_pkg::RD_ACCESS_CYC;
                        s_nxt.st = sram_host_pkg::ST_RD_ACCESS;
                    end
                end
            end

            sram_host_pkg::ST_WR_SETUP: begin
                // Address stable one cycle before strobe; select and strobe fall together
                s_nxt.sel_n = 1'b0; // [RQ6] [RQ13]
                s_nxt.wr_n = 1'b0; // [RQ2] [RQ3]
                s_nxt.oe_n = 1'b1; // [RQ8]
                s_nxt.dq_oe = 1'b1; // [RQ12]
                s_nxt.cnt = sram_host_pkg::WR_PULSE_CYC;
                s_nxt.st = sram_host_pkg::ST_WR_PULSE;
            end

            sram_host_pkg::ST_WR_PULSE: begin
                // Count out the strobe pulse
                if (cnt_last) begin
                    // Strobe and select rise together; address and data held one more cycle
                    s_nxt.sel_n = 1'b1; // [RQ2] [RQ7]
                    s_nxt.wr_n = 1'b1;
                    s_nxt.cnt = sram_host_pkg::RECOV_CYC;
                    s_nxt.st = sram_host_pkg::ST_WR_RECOV;
                end else begin
                    s_nxt.cnt = cnt_dec; // [RQ7]
                end
            end

            sram_host_pkg::ST_WR_RECOV: begin
                // Address and data stand through recovery; the bus is let go as it ends
                s_nxt.dq_oe = 1'b0; // [RQ5]
                if (cnt_last) begin
                    s_nxt.ready = 1'b1;
                    s_nxt.st = sram_host_pkg::ST_IDLE;
                end else begin
                    s_nxt.cnt = cnt_dec; // [RQ4]
                end
            end

            sram_host_pkg::ST_RD_ACCESS: begin
                // Address was set last cycle, before select falls
                s_nxt.sel_n = 1'b0; // [RQ10]
                s_nxt.oe_n = 1'b0; // [RQ16]
                s_nxt.wr_n = 1'b1; // [RQ9]
                s_nxt.dq_oe = 1'b0;
                if (cnt_spent) begin
                    s_nxt.st = sram_host_pkg::ST_RD_DONE;
                end else begin
                    s_nxt.cnt = cnt_dec;
                end
            end

            sram_host_pkg::ST_RD_DONE: begin
                // Wait two cycles for the synchroniser to carry settled data
                if (cnt_spent) begin
                    s_nxt.cnt = sram_host_pkg::CNT_ONE;
                end else begin
                    s_nxt.rdata = s_r.sync2; // [RQ11] [RQ14]
                    s_nxt.rvalid = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.ready = 1'b1;
                    s_nxt.cnt = sram_host_pkg::CNT_ZERO;
                    s_nxt.st = sram_host_pkg::ST_IDLE;
                end
            end

            default: begin
                // Unused state code: park the pins and return to idle
                s_nxt.st = sram_host_pkg::ST_IDLE;
                s_nxt.cnt = sram_host_pkg::CNT_ZERO;
                s_nxt.ready = 1'b1;
                s_nxt.sel_n = 1'b1;
                s_nxt.wr_n = 1'b1;
                s_nxt.oe_n = 1'b1;
                s_nxt.dq_oe = 1'b0;
            end
        endcase
    end

    // Reset is asynchronous; every state bit returns to the standby image
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pins come straight from the state register
    assign o_ready = s_r.ready;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_mem_addr = s_r.addr;
    assign o_mem_sel_n = s_r.sel_n;
    assign o_mem_wr_n = s_r.wr_n;
    assign o_mem_oe_n = s_r.oe_n;
    assign o_mem_dq_o = s_r.dq_o;
    assign o_mem_dq_oe = s_r.dq_oe;
endmodule

// ==== verif/sram_host_ctrl_properties.sv ====
/* Pin timing checks for sram_host_ctrl. Assumes one clock and the bind below. */
`timescale 1ns/10ps
module sram_host_ctrl_check (
    input wire logic i_clk, // Clock
    input wire logic i_sys_rst, // Reset
    input wire logic [14:0] o_mem_addr, // Address pins
    input wire logic o_mem_sel_n, // Select
    input wire logic o_mem_wr_n, // Strobe
    input wire logic o_mem_oe_n, // Output enable
    input wire logic [7:0] o_mem_dq_o, // Data out
    input wire logic o_mem_dq_oe // Data drive
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    chk_addr_strobe_high: assert property (
        !$stable(o_mem_addr) |-> o_mem_wr_n && $past(o_mem_wr_n)) else $error("addr moved");
    chk_read_strobe_high: assert property (!o_mem_oe_n |-> o_mem_wr_n)
        else $error("strobe low in read");
    chk_sel_addr_valid: assert property ($fell(o_mem_sel_n) |-> $stable(o_mem_addr))
        else $error("addr moved at select");
    chk_addr_hold_end: assert property (
        $rose(o_mem_wr_n) |-> $stable(o_mem_addr) ##1 $stable(o_mem_addr)) else $error("addr hold");
    chk_data_release: assert property ($rose(o_mem_wr_n) |-> o_mem_dq_oe ##1 !o_mem_dq_oe)
        else $error("bus not released");
    chk_pulse_width: assert property ($fell(o_mem_wr_n) |->
        (!o_mem_wr_n && o_mem_dq_oe && $stable(o_mem_dq_o))[*2] ##1 o_mem_wr_n) else $error("pulse");
    chk_write_oe_high: assert property (!o_mem_wr_n |-> !o_mem_sel_n && o_mem_oe_n)
        else $error("write pins");
    chk_sel_to_end: assert property (
        $rose(o_mem_wr_n) |-> $rose(o_mem_sel_n) && $past(o_mem_sel_n, 2) == 1'b0) else $error("sel");
    chk_no_contention: assert property (o_mem_dq_oe |-> o_mem_oe_n)
        else $error("bus contention");
endmodule
bind sram_host_ctrl sram_host_ctrl_check u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_mem_addr(o_mem_addr), .o_mem_sel_n(o_mem_sel_n), .o_mem_wr_n(o_mem_wr_n),
    .o_mem_oe_n(o_mem_oe_n), .o_mem_dq_o(o_mem_dq_o), .o_mem_dq_oe(o_mem_dq_oe));

// ==== verif/sram_mem_model.sv ====
/* Behavioural 32K x 8 static memory. Assumes the bench resolves the data bus. */
`timescale 1ns/10ps
module sram_mem_model (
    input wire logic [14:0] i_addr, // Address
    input wire logic i_sel_n, // Select
    input wire logic i_wr_n, // Strobe
    input wire logic i_oe_n, // Output enable
    input wire logic [7:0] i_dq, // Bus level
    output logic [7:0] o_dq, // Read data
    output logic o_dq_oe // Drives bus
);
    logic [7:0] mem_r [32768];
    wire write_end = i_sel_n | i_wr_n;
    always @(posedge write_end) mem_r[i_addr] <= i_dq;
    assign #3 o_dq = mem_r[i_addr];
    assign o_dq_oe = !i_sel_n && i_wr_n && !i_oe_n;
endmodule

// ==== verif/tb_async_sram_bus_cycle_timing.sv ====
/* Bench for sram_host_ctrl. Assumes the memory model and bound checker. */
`timescale 1ns/10ps
module tb_async_sram_bus_cycle_timing;
    logic i_clk = 0, i_sys_rst = 1, i_req = 0, i_we = 0, mem_oe;
    logic o_ready, o_rvalid, o_mem_sel_n, o_mem_wr_n, o_mem_oe_n, o_mem_dq_oe;
    logic [14:0] i_addr = 15'h0000, o_mem_addr;
    logic [7:0] i_wdata = 8'h00, last_r = 8'h00, o_rdata, o_mem_dq_o, mem_dq, dq_w;
    int err_count = 0, tests_run = 0;
    // Rows: write flag, address, data written or expected
    localparam logic [23:0] ROWS [6] = '{24'h80_00A5, 24'hFF_FF5A, 24'h92_343C,
        24'h00_00A5, 24'h7F_FF5A, 24'h12_343C};
    always #50 i_clk = ~i_clk;
    // Floating bus toggles so stale data never reads back
    assign dq_w = o_mem_dq_oe ? o_mem_dq_o : mem_oe ? mem_dq : ~last_r;
    always @(posedge i_clk) last_r <= dq_w;
    sram_host_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_we(i_we),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
        .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_sel_n(o_mem_sel_n),
        .o_mem_wr_n(o_mem_wr_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_dq_o(o_mem_dq_o),
        .o_mem_dq_oe(o_mem_dq_oe), .i_mem_dq_i(dq_w));
    sram_mem_model mem (.i_addr(o_mem_addr), .i_sel_n(o_mem_sel_n), .i_wr_n(o_mem_wr_n),
        .i_oe_n(o_mem_oe_n), .i_dq(dq_w), .o_dq(mem_dq), .o_dq_oe(mem_oe));
    task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task rst_chk;
        cmp("idle", 16'h002E,
            16'({o_ready, o_rvalid, o_mem_sel_n, o_mem_wr_n, o_mem_oe_n, o_mem_dq_oe}));
    endtask
    task op(input logic [23:0] r);
        int n;
        n = 0;
        i_req <= 1'b1;
        {i_we, i_addr, i_wdata} <= r;
        @(posedge i_clk) i_req <= 1'b0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_ready !== 1'b1 && n < 20);
        cmp("ready", 16'h0001, 16'(o_ready));
        if (!r[23]) begin
            cmp("rvalid", 16'h0001, 16'(o_rvalid));
            cmp("rdata", 16'(r[7:0]), 16'(o_rdata));
        end
        @(posedge i_clk);
    endtask
    initial begin
        repeat (3000) @(posedge i_clk);
        cmp("watchdog", 16'h0001, 16'h0000);
        end_sim;
    end
    initial begin
        repeat (6) @(posedge i_clk);
        rst_chk;
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        foreach (ROWS[i]) op(ROWS[i]);
        $display("test rows done");
        i_req <= 1'b1;
        {i_we, i_addr, i_wdata} <= 24'h80_0211;
        @(posedge i_clk) {i_we, i_addr, i_wdata} <= 24'h80_0000;
        @(posedge i_clk) i_req <= 1'b0;
        wait (o_ready === 1'b1);
        @(posedge i_clk);
        op(24'h00_00A5);
        op(24'h00_0211);
        $display("test busy request done");
        i_req <= 1'b1;
        {i_we, i_addr, i_wdata} <= 24'h80_0533;
        @(posedge i_clk) i_req <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b1;
        #1 rst_chk;
        // Held over two edges so no check starts on a half-reset cycle
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        op(24'h12_343C);
        $display("test reset mid write done");
        end_sim;
    end
endmodule
